// [ddp_map.vh]
// Register map, field positions and timing counts of the driver diag/PWM block.
// Included by the block's design files; holds definitions only.
`ifndef DDP_MAP_VH
`define DDP_MAP_VH

// Register indices on the 5-bit register port
`define DDP_ADDR_HB_DIAG 5'h07
`define DDP_ADDR_HS_CTRL 5'h08
`define DDP_ADDR_HB_STAT 5'h0a
`define DDP_ADDR_HS_STAT 5'h0b
`define DDP_ADDR_PWM_DREN 5'h1b
`define DDP_ADDR_PWM_DUTY 5'h1c
`define DDP_ADDR_PWM_FREQ 5'h1d

// Reset values
`define DDP_RST_BYTE 8'h00
`define DDP_RST_NIB 4'h0

// Field positions
`define DDP_NIB_HI 7:4
`define DDP_NIB_LO 3:0

// Timing; 20 us of over-current is 2000 cycles at 100 MHz
`define DDP_OC_CYCLES 11'd2000
`define DDP_OC_W 11
`define DDP_CNT_ONE 8'h01
`define DDP_PRE_ONE 7'd1
`define DDP_PRE_DIV 7'd80
`define DDP_PRE_LAST 7'd79
`define DDP_PRE_ZERO 7'd0
`define DDP_CNT_TOP 8'hff
`define DDP_CNT_ZERO 8'h00

`endif

// [ddp_oc_integrator.v]
// Over-current integrator and sticky flag for one driver.
// Assumes the detector input is synchronous to clock_in.
`timescale 1ns/1ns
`default_nettype none
`include "ddp_map.vh"
module ddp_oc_integrator
(
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Detector and control
  input wire oc_detect_in,
  input wire protect_active_in,
  input wire flag_clear_in,
  // Result
  output reg flag_out
);

  localparam [`DDP_OC_W-1:0] OC_LIMIT = `DDP_OC_CYCLES;
  localparam [`DDP_OC_W-1:0] OC_ONE = 1;
  localparam [`DDP_OC_W-1:0] OC_ZERO = 0;

  reg [`DDP_OC_W-1:0] count_r;
  reg [`DDP_OC_W-1:0] count_nxt;
  wire trip;

  // Count up on over-current, down to zero otherwise
  always @*
  begin
    count_nxt = count_r;
    if (!protect_active_in || flag_out)
      count_nxt = OC_ZERO;
    else if (oc_detect_in)
      count_nxt = count_r + OC_ONE; // RULE_11
    else if (count_r != OC_ZERO)
      count_nxt = count_r - OC_ONE; // RULE_11
  end

  assign trip = protect_active_in && !flag_out && oc_detect_in && (count_r == OC_LIMIT - OC_ONE);

  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_r <= OC_ZERO;
      flag_out <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      // Setting wins over a same-cycle clear
      if (trip)
        flag_out <= 1'b1; // RULE_11
      else if (flag_clear_in)
        flag_out <= 1'b0; // RULE_09
    end
  end

endmodule
`default_nettype wire

// [ddp_driver_ctrl.v]
// Diagnostic source, high-side control/status and PWM gating for eight drivers.
// Assumes a synchronous register port and synchronous, already captured fault levels.
//
// Notes on behaviour
// RULE_01 - Half-bridge diag register: high-side source odd bits, low-side source even bits.
// RULE_02 - Over-temperature clears all half-bridge diagnostic source enables.
// RULE_03 - Any diagnostic source enabled on a driver disables its over-current protection.
// RULE_04 - Open/short flags in upper status nibble read live detector value.
// RULE_05 - High-side control: diag sources upper nibble, driver enables lower nibble.
// RULE_06 - Sleep or standby entry clears all high-side driver enables.
// RULE_07 - Over-temperature clears high-side source enables and driver enables.
// RULE_08 - Captured failure flags gate off every high-side driver enable.
// RULE_09 - Over-current flags clear on write-one; driver stays off while set.
// RULE_10 - High-side over-current protection identical to half-bridge protection.
// RULE_11 - Integrator counts up/down; at 20 us sets flag and disables driver.
// RULE_12 - Software keeps involved drivers off during a diagnostic check.
// RULE_13 - Software enables one partner low-side driver for bridged-load diagnosis.
// RULE_14 - Software turns diagnostic sources off before sleep or standby.
// RULE_15 - Period and duty settings both have eight-bit resolution.
// RULE_16 - After reset duty reads zero and PWM output stays low.
// RULE_17 - Nonzero duty write starts PWM; duty writable any time.
// RULE_18 - Duty copied to shadow only at counter zero crossing.
// RULE_19 - All PWM driver selects zero disables PWM regardless of duty.
// RULE_20 - One PWM signal can modulate any subset of eight drivers.
// RULE_21 - PWM select: high-side upper nibble, half-bridge lower nibble.
// RULE_22 - Counter 0..255; set at zero unless duty zero; clear on match.
// RULE_23 - Counter steps every 80 times (period setting plus one) clocks.
// RULE_24 - Drive command is enable, fault-gated, ANDed with PWM where selected.
`timescale 1ns/1ns
`default_nettype none
`include "ddp_map.vh"
module ddp_driver_ctrl
(
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Register port
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [4:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  // Mode and faults
  input wire sleep_standby_entry_in,
  input wire over_temperature_fault_in,
  input wire over_current_fault_in,
  input wire over_voltage_fault_in,
  input wire under_voltage_fault_in,
  input wire charge_pump_voltage_fault_in,
  // Half-bridge enables from their own register
  input wire [3:0] hb_high_en_in,
  input wire [3:0] hb_low_en_in,
  // Detectors: half-bridge in low nibble, high-side in high nibble
  input wire [7:0] oc_detect_in,
  input wire [3:0] hb_open_short_flag_in,
  input wire [3:0] hs_open_short_flag_in,
  // Diagnostic sources and protection state
  output reg [3:0] hb_high_diag_source_en_out,
  output reg [3:0] hb_low_diag_source_en_out,
  output reg [3:0] hs_diag_source_en_out,
  output reg [7:0] oc_protect_active_out,
  // Driver commands and PWM
  output reg [3:0] hb_high_drive_out,
  output reg [3:0] hb_low_drive_out,
  output reg [3:0] hs_drive_out,
  output reg pwm_out
);

  reg [7:0] hb_diag_r;
  reg [7:0] hs_ctrl_r;
  reg [7:0] pwm_sel_r;
  reg [7:0] pwm_duty_r;
  reg [7:0] pwm_freq_r;
  reg [7:0] pwm_shadow_r;
  reg [7:0] pwm_cnt_r;
  reg [6:0] pre_r;
  reg [7:0] div_r;
  reg pwm_r;
  reg [7:0] rd_nxt;
  wire [7:0] oc_flag;
  wire [7:0] oc_clear;
  wire [7:0] protect;
  wire [3:0] hb_diag_any;
  wire [3:0] hb_src_hi;
  wire [3:0] hb_src_lo;
  wire fault_gate;
  wire pwm_en;
  wire step;
  wire [7:0] cnt_inc;
  wire wr_hb_diag;
  wire wr_hs_ctrl;
  wire wr_hb_stat;
  wire wr_hs_stat;
  wire wr_sel;
  wire wr_duty;
  wire wr_freq;
  wire [3:0] hb_high_cmd;
  wire [3:0] hb_low_cmd;
  wire [3:0] hs_cmd;
  genvar i;

  assign wr_hb_diag = reg_wr_in && (reg_addr_in == `DDP_ADDR_HB_DIAG);
  assign wr_hs_ctrl = reg_wr_in && (reg_addr_in == `DDP_ADDR_HS_CTRL);
  assign wr_hb_stat = reg_wr_in && (reg_addr_in == `DDP_ADDR_HB_STAT);
  assign wr_hs_stat = reg_wr_in && (reg_addr_in == `DDP_ADDR_HS_STAT);
  assign wr_sel = reg_wr_in && (reg_addr_in == `DDP_ADDR_PWM_DREN);
  assign wr_duty = reg_wr_in && (reg_addr_in == `DDP_ADDR_PWM_DUTY);
  assign wr_freq = reg_wr_in && (reg_addr_in == `DDP_ADDR_PWM_FREQ);

  // Diagnostic source enables per driver
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_hbd
      assign hb_src_hi[i] = hb_diag_r[2*i+1]; // RULE_01
      assign hb_src_lo[i] = hb_diag_r[2*i]; // RULE_01
      assign hb_diag_any[i] = hb_src_hi[i] | hb_src_lo[i];
    end
  endgenerate

  assign protect = {~hs_ctrl_r[`DDP_NIB_HI], ~hb_diag_any}; // RULE_03

  // Write-one-to-clear of the over-current flags
  assign oc_clear = {wr_hs_stat ? reg_wdata_in[`DDP_NIB_LO] : `DDP_RST_NIB,
                     wr_hb_stat ? reg_wdata_in[`DDP_NIB_LO] : `DDP_RST_NIB}; // RULE_09

  // Same integrator for half-bridge and high-side drivers
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_oc
      ddp_oc_integrator u_oc
      (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .oc_detect_in(oc_detect_in[i]),
        .protect_active_in(protect[i]),
        .flag_clear_in(oc_clear[i]),
        .flag_out(oc_flag[i])
      ); // RULE_10
    end
  endgenerate

  // Any captured failure gates every driver
  assign fault_gate = over_temperature_fault_in | over_current_fault_in | over_voltage_fault_in |
                      under_voltage_fault_in | charge_pump_voltage_fault_in; // RULE_08

  // Half-bridge diagnostic sources; over-temperature wins over a write
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      hb_diag_r <= `DDP_RST_BYTE;
    else if (over_temperature_fault_in)
      hb_diag_r <= `DDP_RST_BYTE; // RULE_02
    else if (wr_hb_diag)
      hb_diag_r <= reg_wdata_in; // RULE_01
  end

  // High-side control; sleep entry drops only the driver enables
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      hs_ctrl_r <= `DDP_RST_BYTE;
    else if (over_temperature_fault_in)
      hs_ctrl_r <= `DDP_RST_BYTE; // RULE_07
    else if (sleep_standby_entry_in)
      hs_ctrl_r <= {hs_ctrl_r[`DDP_NIB_HI], `DDP_RST_NIB}; // RULE_06
    else if (wr_hs_ctrl)
      hs_ctrl_r <= reg_wdata_in; // RULE_05
  end

  // PWM select; locked while duty is nonzero
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      pwm_sel_r <= `DDP_RST_BYTE;
    else if (sleep_standby_entry_in)
      pwm_sel_r <= `DDP_RST_BYTE;
    else if (wr_sel && (pwm_duty_r == `DDP_RST_BYTE))
      pwm_sel_r <= reg_wdata_in; // RULE_21
  end

  // Duty setting; writable any time, cleared on sleep entry
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      pwm_duty_r <= `DDP_RST_BYTE; // RULE_16
    else if (sleep_standby_entry_in)
      pwm_duty_r <= `DDP_RST_BYTE;
    else if (wr_duty)
      pwm_duty_r <= reg_wdata_in; // RULE_17
  end

  // Period setting
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      pwm_freq_r <= `DDP_RST_BYTE;
    else if (wr_freq)
      pwm_freq_r <= reg_wdata_in; // RULE_15
  end

  // Prescaler: divide by 80, then by period setting plus one
  assign pwm_en = (pwm_sel_r != `DDP_RST_BYTE); // RULE_19
  assign step = (pre_r == `DDP_PRE_LAST) && (div_r == pwm_freq_r); // RULE_23
  assign cnt_inc = pwm_cnt_r + `DDP_CNT_ONE;

  // PWM counter and output, parked at top while disabled
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pre_r <= `DDP_PRE_ZERO;
      div_r <= `DDP_RST_BYTE;
      pwm_cnt_r <= `DDP_CNT_TOP;
      pwm_shadow_r <= `DDP_RST_BYTE;
      pwm_r <= 1'b0; // RULE_16
    end
    else if (!pwm_en)
    begin
      pre_r <= `DDP_PRE_ZERO;
      div_r <= `DDP_RST_BYTE;
      pwm_cnt_r <= `DDP_CNT_TOP;
      pwm_shadow_r <= `DDP_RST_BYTE;
      pwm_r <= 1'b0; // RULE_19
    end
    else
    begin
      if (pre_r == `DDP_PRE_LAST)
      begin
        pre_r <= `DDP_PRE_ZERO;
        div_r <= (div_r == pwm_freq_r) ? `DDP_RST_BYTE : div_r + `DDP_CNT_ONE; // RULE_23
      end
      else
      begin
        pre_r <= pre_r + `DDP_PRE_ONE;
      end
      if (step)
      begin
        pwm_cnt_r <= cnt_inc; // RULE_22
        if (cnt_inc == `DDP_CNT_ZERO)
        begin
          pwm_shadow_r <= pwm_duty_r; // RULE_18
          pwm_r <= (pwm_duty_r != `DDP_RST_BYTE); // RULE_22
        end
        else if (cnt_inc == pwm_shadow_r)
        begin
          pwm_r <= 1'b0; // RULE_22
        end
      end
    end
  end

  // Effective per-driver commands
  assign hb_high_cmd = hb_high_en_in & ~hb_low_en_in & ~oc_flag[`DDP_NIB_LO] & {4{~fault_gate}} &
                       (~pwm_sel_r[`DDP_NIB_LO] | {4{pwm_r}}); // RULE_24
  assign hb_low_cmd = hb_low_en_in & ~hb_high_en_in & ~oc_flag[`DDP_NIB_LO] & {4{~fault_gate}} &
                      (~pwm_sel_r[`DDP_NIB_LO] | {4{pwm_r}}); // RULE_20
  assign hs_cmd = hs_ctrl_r[`DDP_NIB_LO] & ~oc_flag[`DDP_NIB_HI] & {4{~fault_gate}} &
                  (~pwm_sel_r[`DDP_NIB_HI] | {4{pwm_r}}); // RULE_08

  // Read mux; open/short bits sampled live at the read
  always @*
  begin
    rd_nxt = `DDP_RST_BYTE;
    case (reg_addr_in)
      `DDP_ADDR_HB_DIAG: rd_nxt = hb_diag_r;
      `DDP_ADDR_HS_CTRL: rd_nxt = hs_ctrl_r;
      `DDP_ADDR_HB_STAT: rd_nxt = {hb_open_short_flag_in, oc_flag[`DDP_NIB_LO]}; // RULE_04
      `DDP_ADDR_HS_STAT: rd_nxt = {hs_open_short_flag_in, oc_flag[`DDP_NIB_HI]}; // RULE_04
      `DDP_ADDR_PWM_DREN: rd_nxt = pwm_sel_r;
      `DDP_ADDR_PWM_DUTY: rd_nxt = pwm_duty_r;
      `DDP_ADDR_PWM_FREQ: rd_nxt = pwm_freq_r;
      default: rd_nxt = `DDP_RST_BYTE;
    endcase
  end

  // Output flops
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= `DDP_RST_BYTE;
      hb_high_diag_source_en_out <= `DDP_RST_NIB;
      hb_low_diag_source_en_out <= `DDP_RST_NIB;
      hs_diag_source_en_out <= `DDP_RST_NIB;
      oc_protect_active_out <= `DDP_RST_BYTE;
      hb_high_drive_out <= `DDP_RST_NIB;
      hb_low_drive_out <= `DDP_RST_NIB;
      hs_drive_out <= `DDP_RST_NIB;
      pwm_out <= 1'b0;
    end
    else
    begin
      if (reg_rd_in)
        reg_rdata_out <= rd_nxt;
      hb_high_diag_source_en_out <= hb_src_hi; // RULE_01
      hb_low_diag_source_en_out <= hb_src_lo; // RULE_01
      hs_diag_source_en_out <= hs_ctrl_r[`DDP_NIB_HI]; // RULE_05
      oc_protect_active_out <= protect; // RULE_03
      hb_high_drive_out <= hb_high_cmd;
      hb_low_drive_out <= hb_low_cmd;
      hs_drive_out <= hs_cmd; // RULE_09
      pwm_out <= pwm_r;
    end
  end

endmodule
`default_nettype wire

// [ddp_host_model.sv]
// Host model driving the block's register port.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module ddp_host_model
(
  // Clock
  input wire logic clock_in,
  // Register port
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [4:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 5'h00;
    reg_wdata_out = 8'h00;
  end
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clock_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= v;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~v;
  endtask
  task rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clock_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clock_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    @(negedge clock_in);
    v = reg_rdata_in;
  endtask
  // Sources off before sleep, high-side driver enables written from en
  task sleep_prep(input logic [3:0] en);
    wr(5'h07, 8'h00);
    wr(5'h08, {4'h0, en});
  endtask
endmodule
`default_nettype wire

// [ddp_monitor.sv]
// Port assertions for the driver diag/PWM block.
// Assumes one clock and an async active-high reset.
`timescale 1ns/1ns
`default_nettype none
module ddp_monitor
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Inputs
  input wire logic reg_rd_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic sleep_standby_entry_in,
  input wire logic over_temperature_fault_in,
  input wire logic over_current_fault_in,
  input wire logic over_voltage_fault_in,
  input wire logic under_voltage_fault_in,
  input wire logic charge_pump_voltage_fault_in,
  input wire logic [7:0] oc_detect_in,
  input wire logic [3:0] hs_open_short_flag_in,
  // Outputs
  input wire logic [7:0] reg_rdata_out,
  input wire logic [3:0] hb_high_diag_source_en_out,
  input wire logic [3:0] hb_low_diag_source_en_out,
  input wire logic [3:0] hs_diag_source_en_out,
  input wire logic [7:0] oc_protect_active_out,
  input wire logic [3:0] hb_high_drive_out,
  input wire logic [3:0] hb_low_drive_out,
  input wire logic [3:0] hs_drive_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire flt = over_temperature_fault_in | over_current_fault_in | over_voltage_fault_in
    | under_voltage_fault_in | charge_pump_voltage_fault_in;
  wire [7:0] diag = {hs_diag_source_en_out, hb_high_diag_source_en_out | hb_low_diag_source_en_out};
  logic [11:0] oc_run_r;
  // Cycles of unbroken HS1 over-current with protection on
  always @(posedge clock_in or posedge rst_in)
    if (rst_in)
      oc_run_r <= 12'h000;
    else if (!(oc_detect_in[4] && oc_protect_active_out[4]))
      oc_run_r <= 12'h000;
    else if (oc_run_r != 12'hfff)
      oc_run_r <= oc_run_r + 12'h001;
  chk_oc_trip: assert property (oc_run_r >= 12'h7d3 |-> !hs_drive_out[0])
    else $error("hs1 driven past trip");
  chk_fault_gate: assert property (flt [*2] |=> {hb_high_drive_out, hb_low_drive_out, hs_drive_out} == 12'h000)
    else $error("drive during fault");
  chk_ot_clear: assert property (over_temperature_fault_in [*2] |=> diag == 8'h00)
    else $error("sources on in over-temperature");
  chk_sleep_clear: assert property ($rose(sleep_standby_entry_in) |-> ##2 hs_drive_out == 4'h0)
    else $error("hs drive after sleep");
  chk_protect_off: assert property (diag != 8'h00 && $stable(diag) |-> (oc_protect_active_out & diag) == 8'h00)
    else $error("protection on with source");
  chk_rd_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved");
  chk_rd_unmapped: assert property (reg_rd_in && reg_addr_in == 5'h1f |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_os_live: assert property (reg_rd_in && reg_addr_in == 5'h0b
    |=> reg_rdata_out[7:4] == $past(hs_open_short_flag_in))
    else $error("open/short not live");
endmodule
`default_nettype wire

// [ddp_driver_ctrl_test.sv]
// Self-checking bench for the driver diag/PWM block.
// Assumes the host model and monitor are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module ddp_driver_ctrl_test;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic sleep_standby_entry_in = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [3:0] hb_high_en_in = 4'h0;
  logic [3:0] hb_low_en_in = 4'h0;
  logic [7:0] oc_detect_in = 8'h00;
  logic [3:0] hb_open_short_flag_in = 4'h0;
  logic [3:0] hs_open_short_flag_in = 4'h0;
  logic reg_wr_in, reg_rd_in, pwm_out;
  logic [4:0] reg_addr_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, oc_protect_active_out, d;
  logic [3:0] hb_high_diag_source_en_out, hb_low_diag_source_en_out, hs_diag_source_en_out;
  logic [3:0] hb_high_drive_out, hb_low_drive_out, hs_drive_out;
  wire over_current_fault_in = flt[0];
  wire over_voltage_fault_in = flt[1];
  wire under_voltage_fault_in = flt[2];
  wire charge_pump_voltage_fault_in = flt[3];
  wire over_temperature_fault_in = flt[4];
  int fails = 0, checked = 0, cycles = 0, n, bad = 0;
  // Address, write data, open/short input, read expectation
  localparam logic [24:0] ROWS [7] = '{
    {5'h07, 8'ha5, 4'h0, 8'ha5},
    {5'h08, 8'h30, 4'h0, 8'h30},
    {5'h1b, 8'h81, 4'h0, 8'h81},
    {5'h1d, 8'hff, 4'h0, 8'hff},
    {5'h1c, 8'h80, 4'h0, 8'h80},
    {5'h0b, 8'hff, 4'h5, 8'h50},
    {5'h1f, 8'h55, 4'h0, 8'h00}};
  localparam logic [4:0] RA [4] = '{5'h07, 5'h08, 5'h0b, 5'h1c};
  ddp_driver_ctrl u_ddp_driver_ctrl (.clock_in(clock_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .sleep_standby_entry_in(sleep_standby_entry_in), .over_temperature_fault_in(over_temperature_fault_in),
    .over_current_fault_in(over_current_fault_in), .over_voltage_fault_in(over_voltage_fault_in),
    .under_voltage_fault_in(under_voltage_fault_in), .charge_pump_voltage_fault_in(charge_pump_voltage_fault_in),
    .hb_high_en_in(hb_high_en_in), .hb_low_en_in(hb_low_en_in), .oc_detect_in(oc_detect_in),
    .hb_open_short_flag_in(hb_open_short_flag_in), .hs_open_short_flag_in(hs_open_short_flag_in),
    .hb_high_diag_source_en_out(hb_high_diag_source_en_out), .hb_low_diag_source_en_out(hb_low_diag_source_en_out),
    .hs_diag_source_en_out(hs_diag_source_en_out), .oc_protect_active_out(oc_protect_active_out),
    .hb_high_drive_out(hb_high_drive_out), .hb_low_drive_out(hb_low_drive_out), .hs_drive_out(hs_drive_out),
    .pwm_out(pwm_out));
  ddp_host_model u_ddp_host_model (.clock_in(clock_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
  always #5 clock_in = ~clock_in;
  task wr(input logic [4:0] a, input logic [7:0] v);
    u_ddp_host_model.wr(a, v);
  endtask
  task rd(input logic [4:0] a, output logic [7:0] v);
    u_ddp_host_model.rd(a, v);
  endtask
  // Length of next PWM high phase; drive must follow it
  task high_len(output int k);
    k = 0;
    while (pwm_out !== 1'b1)
      @(negedge clock_in);
    while (pwm_out === 1'b1)
    begin
      k++;
      if (hs_drive_out[0] !== pwm_out)
        bad++;
      @(negedge clock_in);
    end
  endtask
  task summarize;
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    hb_low_en_in <= 4'h2;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clock_in);
      hs_open_short_flag_in <= ROWS[i][11:8];
      wr(ROWS[i][24:20], ROWS[i][19:12]);
      rd(ROWS[i][24:20], d);
      `CHK("reg row", ROWS[i][7:0], d)
    end
    `CHK("hb high src", 4'hc, hb_high_diag_source_en_out)
    `CHK("hb low src", 4'h3, hb_low_diag_source_en_out)
    `CHK("hs src", 4'h3, hs_diag_source_en_out)
    `CHK("protect", 8'hc0, oc_protect_active_out)
    `CHK("hb2 low drive", 4'h2, hb_low_drive_out)
    @(posedge clock_in);
    hb_open_short_flag_in <= 4'h9;
    rd(5'h0a, d);
    `CHK("hb status", 8'h90, d)
    wr(5'h08, 8'h01);
    oc_detect_in <= 8'h10;
    repeat (1990) @(negedge clock_in);
    `CHK("hs1 pre trip", 1'b1, hs_drive_out[0])
    repeat (20) @(negedge clock_in);
    `CHK("hs1 tripped", 1'b0, hs_drive_out[0])
    @(posedge clock_in);
    oc_detect_in <= 8'h00;
    rd(5'h0b, d);
    `CHK("oc flag", 8'h01, d)
    wr(5'h0b, 8'h01);
    rd(5'h0b, d);
    `CHK("oc cleared", 8'h00, d)
    `CHK("hs1 back", 1'b1, hs_drive_out[0])
    @(posedge clock_in);
    hb_high_en_in <= 4'h1;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock_in);
      flt <= 5'h01 << i;
      repeat (3) @(negedge clock_in);
      `CHK("gated", 2'b00, {hb_high_drive_out[0], hs_drive_out[0]})
      @(posedge clock_in);
      flt <= 5'h00;
      repeat (3) @(negedge clock_in);
    end
    rd(5'h07, d);
    `CHK("ot hb diag", 8'h00, d)
    rd(5'h08, d);
    `CHK("ot hs ctrl", 8'h00, d)
    u_ddp_host_model.sleep_prep(4'h1);
    sleep_standby_entry_in <= 1'b1;
    @(posedge clock_in);
    sleep_standby_entry_in <= 1'b0;
    rd(5'h08, d);
    `CHK("sleep hs en", 8'h00, d)
    wr(5'h1d, 8'h00);
    wr(5'h1c, 8'h80);
    repeat (20600) @(negedge clock_in)
      if (pwm_out !== 1'b0)
        bad++;
    `CHK("no select", 0, bad)
    wr(5'h1c, 8'h00);
    wr(5'h1b, 8'h10);
    wr(5'h08, 8'h01);
    wr(5'h1c, 8'h80);
    fork
      high_len(n);
      begin
        @(posedge pwm_out);
        wr(5'h1c, 8'h40);
      end
    join
    `CHK("pulse kept", 10240, n)
    high_len(n);
    `CHK("pulse new", 5120, n)
    `CHK("drive follows", 0, bad)
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    `CHK("pwm reset", 1'b0, pwm_out)
    for (int i = 0; i < 4; i++)
    begin
      rd(RA[i], d);
      `CHK("reset value", 8'h00, d)
    end
    summarize();
  end
endmodule
bind ddp_driver_ctrl ddp_monitor u_ddp_monitor (.clock_in(clock_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .sleep_standby_entry_in(sleep_standby_entry_in),
  .over_temperature_fault_in(over_temperature_fault_in), .over_current_fault_in(over_current_fault_in),
  .over_voltage_fault_in(over_voltage_fault_in), .under_voltage_fault_in(under_voltage_fault_in),
  .charge_pump_voltage_fault_in(charge_pump_voltage_fault_in), .oc_detect_in(oc_detect_in),
  .hs_open_short_flag_in(hs_open_short_flag_in), .reg_rdata_out(reg_rdata_out),
  .hb_high_diag_source_en_out(hb_high_diag_source_en_out), .hb_low_diag_source_en_out(hb_low_diag_source_en_out),
  .hs_diag_source_en_out(hs_diag_source_en_out), .oc_protect_active_out(oc_protect_active_out),
  .hb_high_drive_out(hb_high_drive_out), .hb_low_drive_out(hb_low_drive_out), .hs_drive_out(hs_drive_out));
`default_nettype wire
